// ==== design/mag_threshold_pkg.sv ====
package mag_threshold_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h52;
    localparam logic [7:0] ADDR_SOURCE = 8'h53;
    localparam logic [7:0] ADDR_THS_X_HI = 8'h54;
    localparam logic [7:0] ADDR_THS_X_LO = 8'h55;
    localparam logic [7:0] ADDR_THS_Y_HI = 8'h56;
    localparam logic [7:0] ADDR_THS_Y_LO = 8'h57;
    localparam logic [7:0] ADDR_THS_Z_HI = 8'h58;
    localparam logic [7:0] ADDR_THS_Z_LO = 8'h59;
    localparam logic [7:0] ADDR_COUNT = 8'h5a;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [14:0] THS_RESET = 15'h0000;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int NUM_AXES = 3;
    localparam int THS_WIDTH = 15;
    localparam int SAMPLE_WIDTH = 16;
    localparam int DBCNTM_BIT = 7;
    localparam int EA_BIT = 7;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    // Configuration byte, most significant field first
    typedef struct packed {
        logic latch_en;
        logic or_above;
        logic z_en;
        logic y_en;
        logic x_en;
        logic wake_en;
        logic int_en;
        logic int_route_one;
    } config_type;

    // Raw magnetic samples, before offset subtraction
    typedef struct packed {
        logic [SAMPLE_WIDTH-1:0] z;
        logic [SAMPLE_WIDTH-1:0] y;
        logic [SAMPLE_WIDTH-1:0] x;
    } sample_type;

    // Host register port request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

endpackage

// ==== design/magnetic_threshold_detector.sv ====
`timescale 1ns/1ps

module magnetic_threshold_detector (
    input wire logic clock_in, // 25 MHz clock
    input wire logic rst_in, // Asynchronous reset, active high
    input wire mag_threshold_pkg::reg_req_type reg_req_in, // Host register request
    output logic [7:0] reg_rdata_out, // Read data, one cycle after read
    input wire logic sample_valid_in, // One pulse per new sample
    input wire mag_threshold_pkg::sample_type raw_sample_in, // Raw samples, pre-offset
    input wire logic other_int_one_in, // Other sources of line one
    input wire logic other_int_two_in, // Other sources of line two
    output logic interrupt_line_one_out, // Interrupt line one
    output logic interrupt_line_two_out, // Interrupt line two
    output logic wake_event_out, // Flag seen by sleep/wake logic
    output logic event_flag_out // Current threshold event flag
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    mag_threshold_pkg::config_type cfg_q, cfg_d;
    logic [mag_threshold_pkg::NUM_AXES-1:0][mag_threshold_pkg::THS_WIDTH-1:0] ths_q, ths_d;
    logic dbcntm_q, dbcntm_d;
    logic [7:0] count_q, count_d;
    logic [7:0] rdata_q, rdata_d;
    logic src_read;

    // ------------------------------------------------------------
    // Detection state
    // ------------------------------------------------------------
    logic [7:0] cnt_q, cnt_d;
    logic det_q, det_d;
    logic flag_q, flag_d;
    logic [5:0] src_axis_q, src_axis_d;
    logic [5:0] axis_bits_c;
    logic [mag_threshold_pkg::NUM_AXES-1:0] axis_en_c, above_c, below_c, neg_c;
    logic cond_c;
    logic event_flag_c;
    logic [7:0] src_byte_c;

    assign axis_en_c = {cfg_q.z_en, cfg_q.y_en, cfg_q.x_en};
    assign src_read = reg_req_in.read && (reg_req_in.addr == mag_threshold_pkg::ADDR_SOURCE);

    // ------------------------------------------------------------
    // Per-axis compare and combination
    // ------------------------------------------------------------
    always_comb begin
        logic [mag_threshold_pkg::SAMPLE_WIDTH-1:0] smp;
        logic [mag_threshold_pkg::SAMPLE_WIDTH-1:0] mag;
        logic [mag_threshold_pkg::SAMPLE_WIDTH-1:0] ths;
        logic all_below;
        logic any_above;
        smp = '0;
        mag = '0;
        ths = '0;
        all_below = 1'b1;
        any_above = 1'b0;
        axis_bits_c = '0;
        for (int i = 0; i < mag_threshold_pkg::NUM_AXES; i++) begin
            smp = raw_sample_in[i*mag_threshold_pkg::SAMPLE_WIDTH +: mag_threshold_pkg::SAMPLE_WIDTH];
            neg_c[i] = smp[mag_threshold_pkg::SAMPLE_WIDTH-1];
            mag = neg_c[i] ? (~smp + 16'h0001) : smp;
            ths = {1'b0, ths_q[i]};
            above_c[i] = axis_en_c[i] && (mag >= ths);
            below_c[i] = axis_en_c[i] && (mag <= ths);
            if (axis_en_c[i]) begin
                all_below = all_below && below_c[i];
                any_above = any_above || above_c[i];
            end
            axis_bits_c[2*i+1] = cfg_q.or_above ? above_c[i] : below_c[i];
            axis_bits_c[2*i] = axis_en_c[i] && neg_c[i];
        end
        if (cfg_q.or_above) begin
            cond_c = any_above;
        end else begin
            cond_c = all_below && (axis_en_c != '0);
        end
    end

    // ------------------------------------------------------------
    // Debounce counter and event flag
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        det_d = det_q;
        flag_d = flag_q;
        src_axis_d = src_axis_q;
        if (sample_valid_in) begin
            if (cond_c) begin
                if (cnt_q < count_q) begin
                    cnt_d = cnt_q + mag_threshold_pkg::CNT_ONE;
                end else begin
                    cnt_d = count_q;
                end
            end else if (dbcntm_q) begin
                cnt_d = mag_threshold_pkg::CNT_ZERO;
            end else if (cnt_q != mag_threshold_pkg::CNT_ZERO) begin
                cnt_d = cnt_q - mag_threshold_pkg::CNT_ONE;
            end
            det_d = cond_c && (cnt_d == count_q);
            if (!(cfg_q.latch_en && flag_q)) begin
                src_axis_d = axis_bits_c;
            end
        end
        if (!cfg_q.latch_en) begin
            flag_d = 1'b0;
        end else if (src_read) begin
            flag_d = 1'b0;
        end
        if (cfg_q.latch_en && sample_valid_in && det_d) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= mag_threshold_pkg::CNT_ZERO;
            det_q <= 1'b0;
            flag_q <= 1'b0;
            src_axis_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            det_q <= det_d;
            flag_q <= flag_d;
            src_axis_q <= src_axis_d;
        end
    end

    assign event_flag_c = cfg_q.latch_en ? flag_q : det_q;
    assign src_byte_c = {event_flag_c, 1'b0,
                         src_axis_q[5:4] & {2{cfg_q.z_en}},
                         src_axis_q[3:2] & {2{cfg_q.y_en}},
                         src_axis_q[1:0] & {2{cfg_q.x_en}}};

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        ths_d = ths_q;
        dbcntm_d = dbcntm_q;
        count_d = count_q;
        rdata_d = rdata_q;
        if (reg_req_in.write) begin
            if (reg_req_in.addr == mag_threshold_pkg::ADDR_CONFIG) begin
                cfg_d = mag_threshold_pkg::config_type'(reg_req_in.wdata);
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_X_HI) begin
                dbcntm_d = reg_req_in.wdata[mag_threshold_pkg::DBCNTM_BIT];
                ths_d[0][14:8] = reg_req_in.wdata[6:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_X_LO) begin
                ths_d[0][7:0] = reg_req_in.wdata;
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Y_HI) begin
                ths_d[1][14:8] = reg_req_in.wdata[6:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Y_LO) begin
                ths_d[1][7:0] = reg_req_in.wdata;
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Z_HI) begin
                ths_d[2][14:8] = reg_req_in.wdata[6:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Z_LO) begin
                ths_d[2][7:0] = reg_req_in.wdata;
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_COUNT) begin
                count_d = reg_req_in.wdata;
            end
        end
        if (reg_req_in.read) begin
            if (reg_req_in.addr == mag_threshold_pkg::ADDR_CONFIG) begin
                rdata_d = cfg_q;
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_SOURCE) begin
                rdata_d = src_byte_c;
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_X_HI) begin
                rdata_d = {dbcntm_q, ths_q[0][14:8]};
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_X_LO) begin
                rdata_d = ths_q[0][7:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Y_HI) begin
                rdata_d = {1'b0, ths_q[1][14:8]};
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Y_LO) begin
                rdata_d = ths_q[1][7:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Z_HI) begin
                rdata_d = {1'b0, ths_q[2][14:8]};
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_THS_Z_LO) begin
                rdata_d = ths_q[2][7:0];
            end else if (reg_req_in.addr == mag_threshold_pkg::ADDR_COUNT) begin
                rdata_d = count_q;
            end else begin
                rdata_d = mag_threshold_pkg::READ_ZERO;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q <= mag_threshold_pkg::CONFIG_RESET;
            ths_q <= {mag_threshold_pkg::NUM_AXES{mag_threshold_pkg::THS_RESET}};
            dbcntm_q <= 1'b0;
            count_q <= mag_threshold_pkg::COUNT_RESET;
            rdata_q <= mag_threshold_pkg::READ_ZERO;
        end else begin
            cfg_q <= cfg_d;
            ths_q <= ths_d;
            dbcntm_q <= dbcntm_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_q;
    assign event_flag_out = event_flag_c;
    assign wake_event_out = cfg_q.wake_en && event_flag_c;
    assign interrupt_line_one_out = other_int_one_in
                                    || (cfg_q.int_en && cfg_q.int_route_one && event_flag_c);
    assign interrupt_line_two_out = other_int_two_in
                                    || (cfg_q.int_en && !cfg_q.int_route_one && event_flag_c);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_lapse_sample;
        sample_valid_in && !cond_c;
    endsequence

    sequence s_latched_idle;
        cfg_q.latch_en && flag_q && !src_read && !reg_req_in.write;
    endsequence

    a_and_mode: assert property (@(posedge clock_in) disable iff (rst_in)
        (sample_valid_in && !cfg_q.or_above && cfg_q.x_en && !below_c[0]) |=> !det_q)
        else $error("and mode detected with x above threshold");

    a_or_mode: assert property (@(posedge clock_in) disable iff (rst_in)
        (sample_valid_in && cfg_q.or_above && count_q == mag_threshold_pkg::CNT_ZERO
         && (above_c != '0)) |=> det_q)
        else $error("or mode missed an axis above threshold");

    a_debounce_need: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(det_q) |-> $past(cond_c && sample_valid_in)
                         && ($past(cnt_q) + mag_threshold_pkg::CNT_ONE >= $past(count_q)))
        else $error("event flag rose before debounce elapsed");

    a_follow_mode: assert property (@(posedge clock_in) disable iff (rst_in)
        !cfg_q.latch_en |-> (event_flag_out == det_q))
        else $error("unlatched flag does not follow detection");

    a_follow_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cfg_q.latch_en && sample_valid_in && !cond_c && !reg_req_in.write) |=> !event_flag_out)
        else $error("unlatched flag held after condition lapsed");

    a_latch_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        s_latched_idle |=> flag_q)
        else $error("latched flag dropped without a source read");

    a_read_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (cfg_q.latch_en && src_read && !sample_valid_in) |=> !flag_q)
        else $error("source read did not clear latched flag");

    a_disabled_axis: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cfg_q.or_above && axis_en_c == 3'b001 && sample_valid_in
         && below_c[0] && count_q == mag_threshold_pkg::CNT_ZERO) |=> det_q)
        else $error("disabled axes blocked and combination");

    a_wake_gate: assert property (@(posedge clock_in) disable iff (rst_in)
        wake_event_out == (cfg_q.wake_en && event_flag_out))
        else $error("wake output mismatch");

    a_int_route: assert property (@(posedge clock_in) disable iff (rst_in)
        (event_flag_out && cfg_q.int_en) |->
        (cfg_q.int_route_one ? interrupt_line_one_out : interrupt_line_two_out))
        else $error("flag not routed to selected line");

    a_int_gate: assert property (@(posedge clock_in) disable iff (rst_in)
        !cfg_q.int_en |-> (interrupt_line_one_out == other_int_one_in)
                          && (interrupt_line_two_out == other_int_two_in))
        else $error("threshold interrupt with enable clear");

    a_src_mask: assert property (@(posedge clock_in) disable iff (rst_in)
        (src_read && !cfg_q.y_en && !reg_req_in.write) |=> reg_rdata_out[3:2] == 2'b00)
        else $error("disabled axis bits read nonzero");

    a_src_active: assert property (@(posedge clock_in) disable iff (rst_in)
        src_read |=> reg_rdata_out[mag_threshold_pkg::EA_BIT] == $past(event_flag_out))
        else $error("event active bit mismatch");

    a_cnt_bound: assert property (@(posedge clock_in) disable iff (rst_in)
        sample_valid_in |=> cnt_q <= $past(count_q))
        else $error("debounce counter passed count");

    a_lapse_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (s_lapse_sample and dbcntm_q) |=> cnt_q == mag_threshold_pkg::CNT_ZERO)
        else $error("counter not cleared on lapse");

    a_lapse_dec: assert property (@(posedge clock_in) disable iff (rst_in)
        (s_lapse_sample and (!dbcntm_q && cnt_q != mag_threshold_pkg::CNT_ZERO))
        |=> cnt_q == $past(cnt_q) - mag_threshold_pkg::CNT_ONE)
        else $error("counter not decremented on lapse");

    a_per_sample: assert property (@(posedge clock_in) disable iff (rst_in)
        !sample_valid_in |=> $stable(cnt_q) && $stable(det_q))
        else $error("counter moved without a sample");

endmodule

// ==== tb/mag_host_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host software model: byte register reads and writes
// ------------------------------------------------------------
module mag_host_model (
    input wire logic clock_in, // Bench clock
    input wire logic [7:0] rdata_in, // Read data from the block
    output mag_threshold_pkg::reg_req_type req_out // Register request
);
    initial begin
        req_out = '0;
    end

    // Request held for one taking edge, then dropped
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        req_out <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
        @(posedge clock_in);
        req_out.write <= 1'b0;
        #1;
    endtask

    // Read data lands at the taking edge and is taken just after it
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock_in);
        req_out <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clock_in);
        req_out.read <= 1'b0;
        #1;
        data = rdata_in;
    endtask
endmodule

// ==== tb/magnetic_threshold_detector_tb_top.sv ====
`timescale 1ns/1ps

module magnetic_threshold_detector_tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic sample_valid_in = 1'b0;
    mag_threshold_pkg::sample_type raw_sample_in = '0;
    logic other_int_one_in = 1'b0;
    logic other_int_two_in = 1'b0;
    mag_threshold_pkg::reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic line_one;
    logic line_two;
    logic wake_event;
    logic event_flag;
    int bad_count = 0;
    int cmp_count = 0;

    always #20 clock_in = ~clock_in;

    magnetic_threshold_detector DUT (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .reg_req_in(reg_req),
        .reg_rdata_out(reg_rdata),
        .sample_valid_in(sample_valid_in),
        .raw_sample_in(raw_sample_in),
        .other_int_one_in(other_int_one_in),
        .other_int_two_in(other_int_two_in),
        .interrupt_line_one_out(line_one),
        .interrupt_line_two_out(line_two),
        .wake_event_out(wake_event),
        .event_flag_out(event_flag)
    );

    mag_host_model host (
        .clock_in(clock_in),
        .rdata_in(reg_rdata),
        .req_out(reg_req)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        host.write_reg(addr, data);
    endtask

    // One sample pulse; the flag is settled just after its taking edge
    task automatic sample(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge clock_in);
        sample_valid_in <= 1'b1;
        raw_sample_in <= '{z: z, y: y, x: x};
        @(posedge clock_in);
        sample_valid_in <= 1'b0;
        #1;
    endtask

    task automatic flag_is(input logic exp);
        check({7'h00, event_flag}, {7'h00, exp});
    endtask

    initial begin
        repeat (5000) @(posedge clock_in);
        bad_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(mag_threshold_pkg::ADDR_CONFIG, mag_threshold_pkg::CONFIG_RESET);
        rd(mag_threshold_pkg::ADDR_SOURCE, 8'h00);
        rd(mag_threshold_pkg::ADDR_COUNT, mag_threshold_pkg::COUNT_RESET);
        rd(8'h60, mag_threshold_pkg::READ_ZERO);
        wr(mag_threshold_pkg::ADDR_SOURCE, 8'hff);
        rd(mag_threshold_pkg::ADDR_SOURCE, 8'h00);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'ha5);
        rd(mag_threshold_pkg::ADDR_CONFIG, 8'ha5);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'h00);
        flag_is(1'b0);
        // Above mode on x only, count of two, decrementing counter
        wr(mag_threshold_pkg::ADDR_THS_X_HI, 8'h00);
        wr(mag_threshold_pkg::ADDR_THS_X_LO, 8'h64);
        wr(mag_threshold_pkg::ADDR_THS_Y_LO, 8'h0a);
        wr(mag_threshold_pkg::ADDR_COUNT, 8'h02);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'h4f);
        sample(16'h0064, 16'h4000, 16'h0000);
        flag_is(1'b0);
        repeat (5) @(posedge clock_in);
        #1;
        flag_is(1'b0);
        sample(16'hff38, 16'h4000, 16'h0000);
        flag_is(1'b1);
        check({6'h00, line_one, line_two}, 8'h02);
        check({7'h00, wake_event}, 8'h01);
        rd(mag_threshold_pkg::ADDR_SOURCE, 8'h83);
        sample(16'h00c8, 16'h0000, 16'h0000);
        sample(16'h0063, 16'h0000, 16'h0000);
        flag_is(1'b0);
        sample(16'h0064, 16'h0000, 16'h0000);
        flag_is(1'b1);
        sample(16'h0000, 16'h4000, 16'h0000);
        flag_is(1'b0);
        sample(16'h0064, 16'h0000, 16'h0000);
        flag_is(1'b1);
        // Every interrupt enable and route setting with the flag raised, wake enable clear
        for (int i = 0; i < 4; i++) begin
            wr(mag_threshold_pkg::ADDR_CONFIG, 8'h48 | 8'(i));
            check({7'h00, line_one}, 8'(i == 3));
            check({7'h00, line_two}, 8'(i == 2));
            check({7'h00, wake_event}, 8'h00);
        end
        @(posedge clock_in);
        other_int_two_in <= 1'b1;
        @(posedge clock_in);
        #1;
        check({6'h00, line_one, line_two}, 8'h03);
        other_int_two_in <= 1'b0;
        // Clearing counter mode
        wr(mag_threshold_pkg::ADDR_THS_X_HI, 8'h80);
        sample(16'h0000, 16'h0000, 16'h0000);
        sample(16'h0064, 16'h0000, 16'h0000);
        flag_is(1'b0);
        // Below mode on x and y, full-scale x threshold, no debounce
        wr(mag_threshold_pkg::ADDR_THS_X_HI, 8'h7f);
        wr(mag_threshold_pkg::ADDR_THS_X_LO, 8'hff);
        wr(mag_threshold_pkg::ADDR_THS_Y_LO, 8'h32);
        wr(mag_threshold_pkg::ADDR_COUNT, 8'h00);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'h18);
        sample(16'h7fff, 16'h0032, 16'h7fff);
        flag_is(1'b1);
        sample(16'h8000, 16'h0000, 16'h0000);
        flag_is(1'b0);
        sample(16'h0000, 16'h0033, 16'h0000);
        flag_is(1'b0);
        sample(16'h0000, 16'hffce, 16'h0000);
        flag_is(1'b1);
        // Latched above mode on x
        wr(mag_threshold_pkg::ADDR_THS_X_HI, 8'h00);
        wr(mag_threshold_pkg::ADDR_THS_X_LO, 8'h64);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'hc8);
        sample(16'h0064, 16'h0000, 16'h0000);
        flag_is(1'b1);
        sample(16'h0000, 16'h0000, 16'h0000);
        flag_is(1'b1);
        rd(mag_threshold_pkg::ADDR_SOURCE, 8'h82);
        flag_is(1'b0);
        // Above mode on z only, unlatched, no debounce
        wr(mag_threshold_pkg::ADDR_THS_Z_LO, 8'h10);
        wr(mag_threshold_pkg::ADDR_CONFIG, 8'h60);
        sample(16'h0000, 16'h0000, 16'h0010);
        flag_is(1'b1);
        rd(mag_threshold_pkg::ADDR_SOURCE, 8'ha0);
        rd(mag_threshold_pkg::ADDR_THS_Z_HI, 8'h00);
        sample(16'h0000, 16'h0000, 16'h000f);
        flag_is(1'b0);
        finish_test();
    end
endmodule
